// ### src/arm_pkg.sv
// Constants and types for the accelerometer register bank
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
package arm_pkg;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;

    localparam logic [6:0] ADDR_ID       = 7'h0f;
    localparam logic [6:0] ADDR_CTRL1    = 7'h20;
    localparam logic [6:0] ADDR_CTRL2    = 7'h21;
    localparam logic [6:0] ADDR_CTRL3    = 7'h22;
    localparam logic [6:0] ADDR_CTRL4    = 7'h23;
    localparam logic [6:0] ADDR_CTRL5    = 7'h24;
    localparam logic [6:0] ADDR_HPCLR    = 7'h25;
    localparam logic [6:0] ADDR_REF      = 7'h26;
    localparam logic [6:0] ADDR_STATUS   = 7'h27;
    localparam logic [6:0] ADDR_XL       = 7'h28;
    localparam logic [6:0] ADDR_XH       = 7'h29;
    localparam logic [6:0] ADDR_YL       = 7'h2a;
    localparam logic [6:0] ADDR_YH       = 7'h2b;
    localparam logic [6:0] ADDR_ZL       = 7'h2c;
    localparam logic [6:0] ADDR_ZH       = 7'h2d;
    localparam logic [6:0] ADDR_EV1_CFG  = 7'h30;
    localparam logic [6:0] ADDR_EV1_SRC  = 7'h31;
    localparam logic [6:0] ADDR_EV1_THS  = 7'h32;
    localparam logic [6:0] ADDR_EV1_DUR  = 7'h33;
    localparam logic [6:0] ADDR_EV2_CFG  = 7'h34;
    localparam logic [6:0] ADDR_EV2_SRC  = 7'h35;
    localparam logic [6:0] ADDR_EV2_THS  = 7'h36;
    localparam logic [6:0] ADDR_EV2_DUR  = 7'h37;

    localparam logic [7:0] CTRL1_RESET   = 8'h07;
    localparam logic [7:0] RW_RESET      = 8'h00;
    localparam logic [7:0] STATUS_RESET  = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    localparam int PM_MSB = 7;
    localparam int PM_LSB = 5;
    localparam int DR_MSB = 4;
    localparam int DR_LSB = 3;
    localparam int Z_EN_BIT = 2;
    localparam int Y_EN_BIT = 1;
    localparam int X_EN_BIT = 0;

    localparam logic [2:0] PM_POWER_OFF = 3'h0;
    localparam logic [2:0] PM_NORMAL    = 3'h1;
    localparam logic [2:0] PM_LP_0P5    = 3'h2;
    localparam logic [2:0] PM_LP_1      = 3'h3;
    localparam logic [2:0] PM_LP_2      = 3'h4;
    localparam logic [2:0] PM_LP_5      = 3'h5;
    localparam logic [2:0] PM_LP_10     = 3'h6;

    // Rates in tenths of a hertz, cutoffs in hertz
    localparam logic [13:0] RATE_50    = 14'h01f4;
    localparam logic [13:0] RATE_100   = 14'h03e8;
    localparam logic [13:0] RATE_400   = 14'h0fa0;
    localparam logic [13:0] RATE_1000  = 14'h2710;
    localparam logic [13:0] RATE_LP0P5 = 14'h0005;
    localparam logic [13:0] RATE_LP1   = 14'h000a;
    localparam logic [13:0] RATE_LP2   = 14'h0014;
    localparam logic [13:0] RATE_LP5   = 14'h0032;
    localparam logic [13:0] RATE_LP10  = 14'h0064;
    localparam logic [9:0]  CUT_37     = 10'h025;
    localparam logic [9:0]  CUT_74     = 10'h04a;
    localparam logic [9:0]  CUT_292    = 10'h124;
    localparam logic [9:0]  CUT_780    = 10'h30c;

    typedef enum logic [1:0] {
        ARM_OFF = 2'b00,
        ARM_NORMAL = 2'b01,
        ARM_LOW_POWER = 2'b10
    } arm_mode_t;

    typedef struct packed {
        logic            wr_en;
        logic            rd_en;
        logic [6:0]      addr;
        logic [7:0]      wdata;
    } arm_req_t;

    typedef struct packed {
        arm_mode_t       mode;
        logic [13:0]     sample_rate;
        logic [1:0]      resolution_sel;
        logic            resolution_valid;
        logic [9:0]      lowpass_cutoff;
        logic [2:0]      axis_enable;
    } arm_cfg_t;

    typedef struct packed {
        logic [15:0]     x;
        logic [15:0]     y;
        logic [15:0]     z;
    } arm_sample_t;

endpackage

// ### src/arm_regbank.sv
// Register bank with power, rate and axis control decoding
module arm_regbank #(
    parameter logic [7:0] DEVICE_ID = 8'h5a  // Arbitrary identifier value
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire arm_pkg::arm_req_t     req,
    output logic [7:0]                 rdata,
    output logic                       rvalid,
    input  wire logic                  calib_load,
    input  wire logic [7:0]            calib_ctrl2,
    input  wire logic [7:0]            sample_status,
    input  wire arm_pkg::arm_sample_t  sample,
    input  wire logic [7:0]            event1_source,
    input  wire logic [7:0]            event2_source,
    output arm_pkg::arm_cfg_t          cfg,
    output logic [7:0]                 filter_boot_control,
    output logic [7:0]                 interrupt_pin_control,
    output logic [7:0]                 scale_selftest_control,
    output logic [7:0]                 sleep_wake_control,
    output logic [7:0]                 filter_reference_value,
    output logic [7:0]                 event1_config,
    output logic [7:0]                 event1_threshold,
    output logic [7:0]                 event1_min_time,
    output logic [7:0]                 event2_config,
    output logic [7:0]                 event2_threshold,
    output logic [7:0]                 event2_min_time,
    output logic                       hp_clear_pulse
);

    // ---------------------------------------------------------
    // Writable register state
    // ---------------------------------------------------------
    logic [7:0] power_rate_axis_control;
    logic [7:0] next_ctrl1;
    logic [7:0] next_ctrl2;
    logic [7:0] next_ctrl3;
    logic [7:0] next_ctrl4;
    logic [7:0] next_ctrl5;
    logic [7:0] next_ref;
    logic [7:0] next_ev1_cfg;
    logic [7:0] next_ev1_ths;
    logic [7:0] next_ev1_dur;
    logic [7:0] next_ev2_cfg;
    logic [7:0] next_ev2_ths;
    logic [7:0] next_ev2_dur;

    always_comb
    begin
        next_ctrl1   = power_rate_axis_control;
        next_ctrl2   = filter_boot_control;
        next_ctrl3   = interrupt_pin_control;
        next_ctrl4   = scale_selftest_control;
        next_ctrl5   = sleep_wake_control;
        next_ref     = filter_reference_value;
        next_ev1_cfg = event1_config;
        next_ev1_ths = event1_threshold;
        next_ev1_dur = event1_min_time;
        next_ev2_cfg = event2_config;
        next_ev2_ths = event2_threshold;
        next_ev2_dur = event2_min_time;
        if (req.wr_en)
        begin
            case (req.addr)
                arm_pkg::ADDR_CTRL1:   next_ctrl1   = req.wdata;
                arm_pkg::ADDR_CTRL2:   next_ctrl2   = req.wdata;
                arm_pkg::ADDR_CTRL3:   next_ctrl3   = req.wdata;
                arm_pkg::ADDR_CTRL4:   next_ctrl4   = req.wdata;
                arm_pkg::ADDR_CTRL5:   next_ctrl5   = req.wdata;
                arm_pkg::ADDR_REF:     next_ref     = req.wdata;
                arm_pkg::ADDR_EV1_CFG: next_ev1_cfg = req.wdata;
                arm_pkg::ADDR_EV1_THS: next_ev1_ths = req.wdata;
                arm_pkg::ADDR_EV1_DUR: next_ev1_dur = req.wdata;
                arm_pkg::ADDR_EV2_CFG: next_ev2_cfg = req.wdata;
                arm_pkg::ADDR_EV2_THS: next_ev2_ths = req.wdata;
                arm_pkg::ADDR_EV2_DUR: next_ev2_dur = req.wdata;
                default:               next_ctrl1   = power_rate_axis_control;
            endcase
        end
        if (calib_load)
        begin
            next_ctrl2 = calib_ctrl2;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            power_rate_axis_control <= arm_pkg::CTRL1_RESET;
            filter_boot_control     <= arm_pkg::RW_RESET;
            interrupt_pin_control   <= arm_pkg::RW_RESET;
            scale_selftest_control  <= arm_pkg::RW_RESET;
            sleep_wake_control      <= arm_pkg::RW_RESET;
            filter_reference_value  <= arm_pkg::RW_RESET;
            event1_config           <= arm_pkg::RW_RESET;
            event1_threshold        <= arm_pkg::RW_RESET;
            event1_min_time         <= arm_pkg::RW_RESET;
            event2_config           <= arm_pkg::RW_RESET;
            event2_threshold        <= arm_pkg::RW_RESET;
            event2_min_time         <= arm_pkg::RW_RESET;
        end
        else
        begin
            power_rate_axis_control <= next_ctrl1;
            filter_boot_control     <= next_ctrl2;
            interrupt_pin_control   <= next_ctrl3;
            scale_selftest_control  <= next_ctrl4;
            sleep_wake_control      <= next_ctrl5;
            filter_reference_value  <= next_ref;
            event1_config           <= next_ev1_cfg;
            event1_threshold        <= next_ev1_ths;
            event1_min_time         <= next_ev1_dur;
            event2_config           <= next_ev2_cfg;
            event2_threshold        <= next_ev2_ths;
            event2_min_time         <= next_ev2_dur;
        end
    end

    // ---------------------------------------------------------
    // Read path
    // ---------------------------------------------------------
    logic [7:0] next_rdata;
    logic       next_rvalid;
    logic       next_hp_clear;

    always_comb
    begin
        next_rdata    = arm_pkg::UNMAPPED_READ;
        next_rvalid   = req.rd_en;
        next_hp_clear = 1'b0;
        if (req.rd_en)
        begin
            case (req.addr)
                arm_pkg::ADDR_ID:      next_rdata = DEVICE_ID;
                arm_pkg::ADDR_CTRL1:   next_rdata = power_rate_axis_control;
                arm_pkg::ADDR_CTRL2:   next_rdata = filter_boot_control;
                arm_pkg::ADDR_CTRL3:   next_rdata = interrupt_pin_control;
                arm_pkg::ADDR_CTRL4:   next_rdata = scale_selftest_control;
                arm_pkg::ADDR_CTRL5:   next_rdata = sleep_wake_control;
                arm_pkg::ADDR_HPCLR:
                begin
                    next_rdata    = arm_pkg::UNMAPPED_READ;
                    next_hp_clear = 1'b1;
                end
                arm_pkg::ADDR_REF:     next_rdata = filter_reference_value;
                arm_pkg::ADDR_STATUS:  next_rdata = sample_status;
                arm_pkg::ADDR_XL:      next_rdata = sample.x[7:0];
                arm_pkg::ADDR_XH:      next_rdata = sample.x[15:8];
                arm_pkg::ADDR_YL:      next_rdata = sample.y[7:0];
                arm_pkg::ADDR_YH:      next_rdata = sample.y[15:8];
                arm_pkg::ADDR_ZL:      next_rdata = sample.z[7:0];
                arm_pkg::ADDR_ZH:      next_rdata = sample.z[15:8];
                arm_pkg::ADDR_EV1_CFG: next_rdata = event1_config;
                arm_pkg::ADDR_EV1_SRC: next_rdata = event1_source;
                arm_pkg::ADDR_EV1_THS: next_rdata = event1_threshold;
                arm_pkg::ADDR_EV1_DUR: next_rdata = event1_min_time;
                arm_pkg::ADDR_EV2_CFG: next_rdata = event2_config;
                arm_pkg::ADDR_EV2_SRC: next_rdata = event2_source;
                arm_pkg::ADDR_EV2_THS: next_rdata = event2_threshold;
                arm_pkg::ADDR_EV2_DUR: next_rdata = event2_min_time;
                default:               next_rdata = arm_pkg::UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rdata          <= arm_pkg::UNMAPPED_READ;
            rvalid         <= 1'b0;
            hp_clear_pulse <= 1'b0;
        end
        else
        begin
            rdata          <= next_rdata;
            rvalid         <= next_rvalid;
            hp_clear_pulse <= next_hp_clear;
        end
    end

    // ---------------------------------------------------------
    // Power, rate and axis decode
    // ---------------------------------------------------------
    logic [2:0] pm;
    logic [1:0] dr;

    assign pm = power_rate_axis_control[arm_pkg::PM_MSB:arm_pkg::PM_LSB];
    assign dr = power_rate_axis_control[arm_pkg::DR_MSB:arm_pkg::DR_LSB];

    always_comb
    begin
        cfg = '0;
        cfg.axis_enable = {power_rate_axis_control[arm_pkg::Z_EN_BIT],
                           power_rate_axis_control[arm_pkg::Y_EN_BIT],
                           power_rate_axis_control[arm_pkg::X_EN_BIT]};
        case (dr)
            2'h0:    cfg.lowpass_cutoff = arm_pkg::CUT_37;
            2'h1:    cfg.lowpass_cutoff = arm_pkg::CUT_74;
            2'h2:    cfg.lowpass_cutoff = arm_pkg::CUT_292;
            default: cfg.lowpass_cutoff = arm_pkg::CUT_780;
        endcase
        case (pm)
            arm_pkg::PM_POWER_OFF:
                cfg.mode = arm_pkg::ARM_OFF;
            arm_pkg::PM_NORMAL:
            begin
                cfg.mode = arm_pkg::ARM_NORMAL;
                case (dr)
                    2'h0:    cfg.sample_rate = arm_pkg::RATE_50;
                    2'h1:    cfg.sample_rate = arm_pkg::RATE_100;
                    2'h2:    cfg.sample_rate = arm_pkg::RATE_400;
                    default: cfg.sample_rate = arm_pkg::RATE_1000;
                endcase
            end
            arm_pkg::PM_LP_0P5,
            arm_pkg::PM_LP_1,
            arm_pkg::PM_LP_2,
            arm_pkg::PM_LP_5,
            arm_pkg::PM_LP_10:
            begin
                cfg.mode = arm_pkg::ARM_LOW_POWER;
                cfg.resolution_sel   = dr;
                cfg.resolution_valid = 1'b1;
                case (pm)
                    arm_pkg::PM_LP_0P5: cfg.sample_rate = arm_pkg::RATE_LP0P5;
                    arm_pkg::PM_LP_1:   cfg.sample_rate = arm_pkg::RATE_LP1;
                    arm_pkg::PM_LP_2:   cfg.sample_rate = arm_pkg::RATE_LP2;
                    arm_pkg::PM_LP_5:   cfg.sample_rate = arm_pkg::RATE_LP5;
                    default:            cfg.sample_rate = arm_pkg::RATE_LP10;
                endcase
            end
            default:
                cfg.mode = arm_pkg::ARM_OFF;
        endcase
    end

endmodule

// ### verification/arm_regbank_assertions.sv
// Port checker for the accelerometer register bank
module arm_regbank_checker #(
    parameter logic [7:0] DEVICE_ID = 8'h5a  // Arbitrary identifier value
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire arm_pkg::arm_req_t req,
    input wire logic [7:0]        rdata,
    input wire logic              rvalid,
    input wire logic              calib_load,
    input wire logic [7:0]        calib_ctrl2,
    input wire arm_pkg::arm_cfg_t cfg,
    input wire logic [7:0]        filter_boot_control,
    input wire logic [7:0]        event1_config,
    input wire logic              hp_clear_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_read_answer:
        assert property (req.rd_en |=> rvalid ##1 (rvalid == $past(req.rd_en)))
        else $error("read not answered in one cycle");
    a_no_stray_answer:
        assert property (!req.rd_en |=> !rvalid) else $error("answer without read");
    a_id_fixed:
        assert property (req.rd_en && req.addr == 7'h0f |=> rdata == DEVICE_ID)
        else $error("identifier read wrong");
    a_reserved_zero:
        assert property (req.rd_en && req.addr inside {[7'h00:7'h0e], [7'h10:7'h1f],
            [7'h2e:7'h2f], [7'h38:7'h7f]} |=> rdata == 8'h00)
        else $error("reserved read not zero");
    a_axis_write:
        assert property (req.wr_en && req.addr == 7'h20 && !req.rd_en
            |=> cfg.axis_enable == $past(req.wdata[2:0]))
        else $error("axis enables not written");
    a_cutoff_map:
        assert property (req.wr_en && req.addr == 7'h20 |=> cfg.lowpass_cutoff ==
            ($past(req.wdata[4]) ? ($past(req.wdata[3]) ? 10'h30c : 10'h124)
                                 : ($past(req.wdata[3]) ? 10'h04a : 10'h025)))
        else $error("cutoff decode wrong");
    a_lp_resolution:
        assert property (req.wr_en && req.addr == 7'h20 && req.wdata[7:5] inside {[3'h2:3'h6]}
            |=> cfg.mode == arm_pkg::ARM_LOW_POWER && cfg.resolution_valid
                && cfg.resolution_sel == $past(req.wdata[4:3]))
        else $error("low-power decode wrong");
    a_hp_pulse:
        assert property ((req.rd_en && req.addr == 7'h25) |=> hp_clear_pulse)
        else $error("filter clear pulse missing");
    a_ro_write_quiet:
        assert property (!req.rd_en |=> !hp_clear_pulse)
        else $error("side effect without read");
    a_calib_load:
        assert property (calib_load |=> filter_boot_control == $past(calib_ctrl2))
        else $error("calibration reload failed");
    a_reset_state:
        assert property (disable iff (1'b0) !rst_n |=> cfg.axis_enable == 3'h7
            && cfg.mode == arm_pkg::ARM_OFF && event1_config == 8'h00 && !rvalid)
        else $error("reset state wrong");
endmodule

bind arm_regbank arm_regbank_checker #(.DEVICE_ID(DEVICE_ID)) i_checker (
    .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
    .calib_load(calib_load), .calib_ctrl2(calib_ctrl2), .cfg(cfg),
    .filter_boot_control(filter_boot_control), .event1_config(event1_config),
    .hp_clear_pulse(hp_clear_pulse));

// ### verification/arm_host.sv
// Host model issuing byte reads and writes to the register bank
module arm_host (
    input  wire logic         clk,
    input  wire logic [7:0]   rdata,
    input  wire logic         rvalid,
    output arm_pkg::arm_req_t req
);
    timeunit 1ns;
    timeprecision 100ps;
    initial req = '0;
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        if (a inside {[7'h00:7'h0e], [7'h10:7'h1f], [7'h2e:7'h2f], [7'h38:7'h7f]})
            return;
        @(posedge clk) #1;
        req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
        @(posedge clk) #1;
        req = '0;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
        @(posedge clk) #1;
        req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk) #1;
        d = rdata;
        v = rvalid;
        req = '0;
    endtask
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the register bank
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] ID = 8'h5a;  // Arbitrary identifier value
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  calib_load = 1'b0;
    logic [7:0]            calib_ctrl2 = 8'h00;
    logic [7:0]            status = 8'h5c;
    logic [7:0]            ev1 = 8'h3e;
    logic [7:0]            ev2 = 8'h71;
    arm_pkg::arm_sample_t  sample = {16'ha1b2, 16'hc3d4, 16'he5f6};
    arm_pkg::arm_req_t     req;
    arm_pkg::arm_cfg_t     cfg;
    logic [7:0]            rdata;
    logic                  rvalid;
    logic                  hp;
    logic [7:0]            boot_ctrl;
    logic [7:0]            ev2_time;
    wire  [7:0]            rw_o [11];
    int                    num_errors = 0;
    int                    tests_run = 0;
    logic [6:0]  rw_a [11] = '{7'h21, 7'h22, 7'h23, 7'h24, 7'h26, 7'h30, 7'h32, 7'h33,
                               7'h34, 7'h36, 7'h37};
    logic [6:0]  ro_a [10] = '{7'h0f, 7'h27, 7'h28, 7'h29, 7'h2a, 7'h2b, 7'h2c, 7'h2d,
                               7'h31, 7'h35};
    logic [7:0]  ro_e [10] = '{ID, 8'h5c, 8'hb2, 8'ha1, 8'hd4, 8'hc3, 8'hf6, 8'he5,
                               8'h3e, 8'h71};
    logic [6:0]  rsv_a [8] = '{7'h00, 7'h0e, 7'h10, 7'h1f, 7'h2e, 7'h2f, 7'h38, 7'h7f};
    logic [13:0] nrm [4] = '{14'h01f4, 14'h03e8, 14'h0fa0, 14'h2710};
    logic [13:0] lpr [5] = '{14'h0005, 14'h000a, 14'h0014, 14'h0032, 14'h0064};
    logic [9:0]  cut [4] = '{10'h025, 10'h04a, 10'h124, 10'h30c};

    always #25 clk = ~clk;

    arm_regbank #(.DEVICE_ID(ID)) i_arm_regbank (
        .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
        .calib_load(calib_load), .calib_ctrl2(calib_ctrl2), .sample_status(status),
        .sample(sample), .event1_source(ev1), .event2_source(ev2), .cfg(cfg),
        .filter_boot_control(boot_ctrl), .interrupt_pin_control(rw_o[1]),
        .scale_selftest_control(rw_o[2]), .sleep_wake_control(rw_o[3]),
        .filter_reference_value(rw_o[4]), .event1_config(rw_o[5]),
        .event1_threshold(rw_o[6]), .event1_min_time(rw_o[7]), .event2_config(rw_o[8]),
        .event2_threshold(rw_o[9]), .event2_min_time(ev2_time), .hp_clear_pulse(hp));
    assign rw_o[0]  = boot_ctrl;
    assign rw_o[10] = ev2_time;
    arm_host i_arm_host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));

    task automatic end_of_test;
        if (num_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rd_chk(input string n, input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       v;
        i_arm_host.rd(a, d, v);
        check({n, " valid"}, 16'h0001, {15'h0000, v});
        check(n, {8'h00, e}, {8'h00, d});
    endtask

    task automatic t_reset_values;
        check("reset mode", 16'h0000, {14'h0000, cfg.mode});
        check("reset cutoff", 16'h0025, {6'h00, cfg.lowpass_cutoff});
        rd_chk("ctrl reset", 7'h20, 8'h07);
        foreach (rw_a[i])
            rd_chk("rw reset", rw_a[i], 8'h00);
    endtask

    task automatic t_ctrl_modes;
        logic [2:0]  p;
        logic [1:0]  r;
        logic        lp;
        logic [13:0] er;
        for (int i = 0; i < 32; i++)
        begin
            p = 3'(i >> 2);
            r = 2'(i);
            lp = (p >= 3'h2) && (p <= 3'h6);
            er = (p == 3'h1) ? nrm[r] : (lp ? lpr[p - 3'h2] : 14'h0000);
            i_arm_host.wr(7'h20, {p, r, 3'(i)});
            check("mode", {14'h0000, lp, p == 3'h1}, {14'h0000, cfg.mode});
            check("rate", {2'h0, er}, {2'h0, cfg.sample_rate});
            check("res", {13'h0000, lp, (lp ? r : 2'h0)},
                  {13'h0000, cfg.resolution_valid, cfg.resolution_sel});
            check("cutoff", {6'h00, cut[r]}, {6'h00, cfg.lowpass_cutoff});
            check("axes", {13'h0000, 3'(i)}, {13'h0000, cfg.axis_enable});
            rd_chk("ctrl", 7'h20, {p, r, 3'(i)});
        end
    endtask

    task automatic t_read_only;
        foreach (ro_a[i])
        begin
            rd_chk("ro", ro_a[i], ro_e[i]);
            i_arm_host.wr(ro_a[i], ~ro_e[i]);
            rd_chk("ro kept", ro_a[i], ro_e[i]);
        end
        i_arm_host.wr(7'h25, 8'hff);
        check("no pulse", 16'h0000, {15'h0000, hp});
        rd_chk("hp clear", 7'h25, 8'h00);
        check("hp pulse", 16'h0001, {15'h0000, hp});
    endtask

    task automatic t_rw_regs;
        foreach (rw_a[i])
            i_arm_host.wr(rw_a[i], 8'(8'h3c + 8'(i * 17)));
        check("boot out", 16'h003c, {8'h00, boot_ctrl});
        check("ev2 time out", 16'h00e6, {8'h00, ev2_time});
        foreach (rw_a[i])
            check("rw out", {8'h00, 8'(8'h3c + 8'(i * 17))}, {8'h00, rw_o[i]});
        foreach (rw_a[i])
            rd_chk("rw", rw_a[i], 8'(8'h3c + 8'(i * 17)));
        foreach (rsv_a[i])
            rd_chk("reserved", rsv_a[i], 8'h00);
    endtask

    task automatic t_calib_and_reset;
        @(posedge clk) #1;
        calib_ctrl2 = 8'ha7;
        calib_load = 1'b1;
        @(posedge clk) #1;
        calib_load = 1'b0;
        check("calib", 16'h00a7, {8'h00, boot_ctrl});
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        rd_chk("ctrl rereset", 7'h20, 8'h07);
        rd_chk("ref rereset", 7'h26, 8'h00);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_of_test();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        t_reset_values();
        t_ctrl_modes();
        t_read_only();
        t_rw_regs();
        t_calib_and_reset();
        end_of_test();
    end
endmodule
